// ==== design/pwm_pkg.sv ====
package pwm_pkg;

  // output-mode field codes
  localparam logic [1:0] OM_SINGLE    = 2'h0;
  localparam logic [1:0] OM_FWD       = 2'h1;
  localparam logic [1:0] OM_HALF      = 2'h2;
  localparam logic [1:0] OM_REV       = 2'h3;
  localparam int         OM_DIR_BIT   = 1;     // direction bit inside the output-mode field
  localparam int         OM_FULL_BIT  = 0;     // set in both full-bridge codes

  // module mode field layout: upper pair selects pwm, lower pair the polarity
  localparam int         MODE_KEY_HI  = 3;
  localparam int         MODE_KEY_LO  = 2;
  localparam logic [1:0] MODE_KEY_PWM = 2'h3;
  localparam int         POL_AC_BIT   = 1;     // set: out_a and out_c active low
  localparam int         POL_BD_BIT   = 0;     // set: out_b and out_d active low

  // pin positions inside four-bit vectors
  localparam int         PIN_A        = 0;
  localparam int         PIN_B        = 1;
  localparam int         PIN_C        = 2;
  localparam int         PIN_D        = 3;

  // timer prescale select and the matching terminal counts
  localparam logic [1:0] PS_SEL_DIV1  = 2'h0;
  localparam logic [1:0] PS_SEL_DIV4  = 2'h1;
  localparam logic [4:0] PS_CNT1      = 5'h00;
  localparam logic [4:0] PS_CNT4      = 5'h03;
  localparam logic [4:0] PS_CNT16     = 5'h0F;

  // one instruction cycle is four system clocks
  localparam logic [1:0] CYC_LAST     = 2'h3;
  localparam logic [1:0] SUB_LAST     = 2'h3;
  localparam int         DB_WIDTH     = 7;

  // reset values
  localparam logic [4:0] PRE_RST      = 5'h00;
  localparam logic [7:0] TMR_RST      = 8'h00;
  localparam logic [9:0] DUTY_RST     = 10'h000;
  localparam logic [3:0] OWN_RST      = 4'h0;
  localparam logic [3:0] OWN_HALF     = 4'h3;
  localparam logic [3:0] OWN_ALL      = 4'hF;

endpackage : pwm_pkg

// ==== design/time_base_if.sv ====
`timescale 1ns/1ps
interface time_base_if;
  logic [7:0] tmr;       // period timer
  logic [1:0] sub;       // two low bits of the 10-bit time base
  logic       boundary;  // one-cycle pulse: timer just wrapped to zero
  logic       lastStep;  // level: final prescaled increment of the period
  logic       cycTick;   // one-cycle pulse per instruction cycle

  modport src (output tmr, output sub, output boundary, output lastStep, output cycTick);
  modport snk (input tmr, input sub, input boundary, input lastStep, input cycTick);
endinterface : time_base_if

// ==== design/pwm_time_base.sv ====
`timescale 1ns/1ps
module pwm_time_base
  import pwm_pkg::*;
(
  input  wire logic       clk,              // system clock
  input  wire logic       reset,            // asynchronous, active high
  input  wire logic       timerRunBit,      // timer runs while high
  input  wire logic [1:0] timerPrescaleSel, // 1, 4 or 16
  input  wire logic [7:0] periodValue,      // period register
  time_base_if.src        tb                // time base bundle
);

  typedef struct packed {
    logic [4:0] pre;
    logic [1:0] sub;
    logic [7:0] tmr;
    logic [1:0] cyc;
    logic       boundary;
    logic       lastStep;
    logic       cycTick;
  } tb_state_t;

  tb_state_t  s_r;
  tb_state_t  s_nxt;
  logic [4:0] preLast;
  logic       step;

  // every rate is an enable taken from clk, so the pwm scales with it
  always_comb begin
    case (timerPrescaleSel)
      PS_SEL_DIV1: preLast = PS_CNT1;
      PS_SEL_DIV4: preLast = PS_CNT4;
      default:     preLast = PS_CNT16;
    endcase
    // >= lets a lowered prescale recover without a wrap
    step = timerRunBit && (s_r.pre >= preLast);
    s_nxt = s_r;
    s_nxt.cyc = s_r.cyc + 2'h1;
    s_nxt.cycTick = (s_r.cyc == CYC_LAST);
    s_nxt.boundary = 1'b0;
    if (timerRunBit) begin
      s_nxt.pre = step ? PRE_RST : s_r.pre + 5'h01;
    end
    if (step) begin
      s_nxt.sub = s_r.sub + 2'h1;
      if (s_r.sub == SUB_LAST) begin
        if (s_r.tmr == periodValue) begin
          s_nxt.tmr = TMR_RST;
          s_nxt.boundary = 1'b1;
        end else begin
          s_nxt.tmr = s_r.tmr + 8'h01;
        end
      end
    end
    s_nxt.lastStep = (s_nxt.tmr == periodValue) && (s_nxt.sub == SUB_LAST);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tb.tmr      = s_r.tmr;
  assign tb.sub      = s_r.sub;
  assign tb.boundary = s_r.boundary;
  assign tb.lastStep = s_r.lastStep;
  assign tb.cycTick  = s_r.cycTick;

  a_timer_wrap: assert property (@(posedge clk) disable iff (reset)
    (step && s_r.sub == SUB_LAST && s_r.tmr == periodValue) |=> (s_r.tmr == TMR_RST && s_r.boundary))
    else $error("timer did not wrap at period match");

endmodule : pwm_time_base

// ==== design/deadband_delay.sv ====
`timescale 1ns/1ps
module deadband_delay
  import pwm_pkg::*;
#(
  parameter int CW = DB_WIDTH                 // width of the delay count
)(
  input  wire logic          clk,            // system clock
  input  wire logic          reset,          // asynchronous, active high
  input  wire logic          cycTick,        // instruction-cycle pulse
  input  wire logic          enable,         // delay applied while high
  input  wire logic          levelIn,        // active-level input
  input  wire logic [CW-1:0] delayCount,     // instruction cycles of delay
  output logic               levelOut        // delayed active level
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          out;
  } db_state_t;

  db_state_t s_r;
  db_state_t s_nxt;

  // only the inactive-to-active edge is held back; the fall is immediate,
  // so a pulse shorter than the delay never shows at all
  always_comb begin
    s_nxt = s_r;
    if (!levelIn) begin
      s_nxt.cnt = '0;
      s_nxt.out = 1'b0;
    end else if (!enable || s_r.cnt >= delayCount) begin
      s_nxt.out = 1'b1;
    end else if (cycTick) begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign levelOut = s_r.out;

  a_dead_wait: assert property (@(posedge clk) disable iff (reset)
    (enable && levelIn && !s_r.out && s_r.cnt < delayCount) |=> !levelOut)
    else $error("output went active before the dead band expired");

  a_dead_fall: assert property (@(posedge clk) disable iff (reset)
    !levelIn |=> !levelOut)
    else $error("output active while its source is inactive");

endmodule : deadband_delay

// ==== design/bridge_pwm_output_steering.sv ====
// Overview of operation
// - all pwm timing derives from the system clock
// - reset releases pins and restores default registers
// - ten-bit pwm on up to four outputs
// - mode codes: 00 single, 10 half, 01/11 full
// - first pulse waits for a period boundary
// - cleared control releases pins; unused pins stay free
// - single mode: steering bits choose driven outputs
// - half bridge: pwm on a, complement on b
// - half bridge delays rising edges by dead band
// - dead band longer than pulse keeps output inactive
// - forward: a active, d modulated, b c inactive
// - reverse: c active, b modulated, a d inactive
// - direction flip: modulated off, unmodulated swap, resume
// - unmodulated swap one prescaled increment before end
// - no dead band in full-bridge modes
// - polarity per a/c pair and b/d pair
// - full cycle first; flag set as period begins
// - at period match: clear timer, set, latch duty
// - pulse ends when time base equals buffered duty
`timescale 1ns/1ps
module bridge_pwm_output_steering
  import pwm_pkg::*;
(
  input  wire logic       clk,              // 25 MHz system clock
  input  wire logic       reset,            // asynchronous, active high
  input  wire logic [3:0] moduleModeField,  // 11xx selects pwm, low bits polarity
  input  wire logic [1:0] outputModeSel,    // bridge mode
  input  wire logic [7:0] dutyHighByte,     // duty bits 9:2
  input  wire logic [1:0] dutyLowBits,      // duty bits 1:0
  input  wire logic [6:0] deadbandCount,    // half-bridge dead band
  input  wire logic [3:0] steerEnable,      // single-mode pin steering d..a
  input  wire logic [7:0] periodValue,      // period register
  input  wire logic [1:0] timerPrescaleSel, // timer prescale 1/4/16
  input  wire logic       timerRunBit,      // timer run
  input  wire logic       flagClear,        // pulse: clear match flag
  output logic            outA,             // pin value a
  output logic            outB,             // pin value b
  output logic            outC,             // pin value c
  output logic            outD,             // pin value d
  output logic [3:0]      pinOwned,         // pins claimed by the module, d..a
  output logic            timerMatchFlag,   // sticky period flag
  output logic [7:0]      periodTimer,      // current timer value
  output logic [9:0]      dutyBuffer        // duty value in use
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,  // module not in pwm mode
    ST_ARMED = 3'b010,  // pwm chosen, waiting for a period start
    ST_RUN   = 3'b100   // generating waveforms
  } run_state_t;

  typedef struct packed {
    run_state_t st;
    logic       pwmRaw;
    logic [9:0] dutyBuf;
    logic       dirR;
    logic       flag;
    logic [3:0] outs;
    logic [3:0] own;
  } top_state_t;

  top_state_t  s_r;
  top_state_t  s_nxt;

  time_base_if tb ();

  logic        pwmMode;
  logic        halfMode;
  logic        fullMode;
  logic        dirSel;
  logic        running;
  logic        pending;
  logic        unmodDir;
  logic        modLevel;
  logic        deadA;
  logic        deadB;
  logic [9:0]  dutyNew;
  logic [9:0]  timeBase;
  logic [3:0]  polV;
  logic [3:0]  act;

  pwm_time_base u_time_base (
    .clk              (clk),
    .reset            (reset),
    .timerRunBit      (timerRunBit),
    .timerPrescaleSel (timerPrescaleSel),
    .periodValue      (periodValue),
    .tb               (tb.src)
  );

  // dead band only in half bridge; elsewhere the instances just pass the level
  deadband_delay #(.CW(DB_WIDTH)) u_dead_a (
    .clk        (clk),
    .reset      (reset),
    .cycTick    (tb.cycTick),
    .enable     (halfMode),
    .levelIn    (s_r.pwmRaw),
    .delayCount (deadbandCount),
    .levelOut   (deadA)
  );

  deadband_delay #(.CW(DB_WIDTH)) u_dead_b (
    .clk        (clk),
    .reset      (reset),
    .cycTick    (tb.cycTick),
    .enable     (halfMode),
    .levelIn    (running && !s_r.pwmRaw),
    .delayCount (deadbandCount),
    .levelOut   (deadB)
  );

  // decode of the control fields
  always_comb begin
    pwmMode  = (moduleModeField[MODE_KEY_HI:MODE_KEY_LO] == MODE_KEY_PWM);
    halfMode = pwmMode && (outputModeSel == OM_HALF);
    fullMode = pwmMode && outputModeSel[OM_FULL_BIT];
    dirSel   = outputModeSel[OM_DIR_BIT];
    running  = (s_r.st == ST_RUN);
    dutyNew  = {dutyHighByte, dutyLowBits};
    timeBase = {tb.tmr, tb.sub};
  end

  // polarity applies per pin pair: a/c from one bit, b/d from the other
  always_comb begin
    polV[PIN_A] = moduleModeField[POL_AC_BIT];
    polV[PIN_C] = moduleModeField[POL_AC_BIT];
    polV[PIN_B] = moduleModeField[POL_BD_BIT];
    polV[PIN_D] = moduleModeField[POL_BD_BIT];
  end

  // direction change: the applied direction only moves at a period start;
  // the unmodulated pair swaps during the last prescaled increment
  // and stays swapped in the wrap cycle, else it would flip back for one clock
  always_comb begin
    pending  = running && fullMode && (dirSel != s_r.dirR);
    unmodDir = (pending && (tb.lastStep || tb.boundary)) ? dirSel : s_r.dirR;
    modLevel = pending ? 1'b0 : deadA;
  end

  // active levels per pin before polarity
  always_comb begin
    act = 4'h0;
    if (running) begin
      case (outputModeSel)
        OM_SINGLE: begin
          act = {4{deadA}} & steerEnable;
        end
        OM_HALF: begin
          act[PIN_A] = deadA;
          act[PIN_B] = deadB;
        end
        default: begin
          if (!unmodDir) begin
            act[PIN_A] = 1'b1;
            act[PIN_D] = modLevel;
          end else begin
            act[PIN_C] = 1'b1;
            act[PIN_B] = modLevel;
          end
        end
      endcase
    end
  end

  // next state of the whole block
  always_comb begin
    s_nxt = s_r;

    // waveform generation starts only at a period boundary
    if (!pwmMode) begin
      s_nxt.st = ST_IDLE;
    end else begin
      case (s_r.st)
        ST_IDLE:  s_nxt.st = ST_ARMED;
        ST_ARMED: s_nxt.st = tb.boundary ? ST_RUN : ST_ARMED;
        ST_RUN:   s_nxt.st = ST_RUN;
        default:  s_nxt.st = ST_IDLE;
      endcase
    end

    // duty is double buffered: new value only taken at the period start
    if (tb.boundary) begin
      s_nxt.dutyBuf = dutyNew;
    end

    // raw pwm: set at period start unless duty is zero, cleared on match;
    // a duty beyond the period never matches and leaves the level set
    if (s_nxt.st != ST_RUN) begin
      s_nxt.pwmRaw = 1'b0;
    end else if (tb.boundary) begin
      s_nxt.pwmRaw = (dutyNew != DUTY_RST);
    end else if (timeBase == s_r.dutyBuf) begin
      s_nxt.pwmRaw = 1'b0;
    end

    // applied direction follows the selection except mid-period in full bridge
    if (!running || !fullMode || tb.boundary) begin
      s_nxt.dirR = dirSel;
    end

    // sticky period flag; a boundary in the clearing cycle still sets it
    if (tb.boundary) begin
      s_nxt.flag = 1'b1;
    end else if (flagClear) begin
      s_nxt.flag = 1'b0;
    end

    // ownership: nothing when pwm is off, only used pins otherwise
    if (!pwmMode) begin
      s_nxt.own = OWN_RST;
    end else begin
      case (outputModeSel)
        OM_SINGLE: s_nxt.own = steerEnable;
        OM_HALF:   s_nxt.own = OWN_HALF;
        default:   s_nxt.own = OWN_ALL;
      endcase
    end

    // pin values: inactive level on owned pins when idle, zero on free pins
    s_nxt.outs = (act ^ polV) & s_nxt.own;
  end

  // one register for all state; reset leaves every pin released
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r.st      <= ST_IDLE;
      s_r.pwmRaw  <= 1'b0;
      s_r.dutyBuf <= DUTY_RST;
      s_r.dirR    <= 1'b0;
      s_r.flag    <= 1'b0;
      s_r.outs    <= 4'h0;
      s_r.own     <= OWN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs come straight from registers
  assign outA           = s_r.outs[PIN_A];
  assign outB           = s_r.outs[PIN_B];
  assign outC           = s_r.outs[PIN_C];
  assign outD           = s_r.outs[PIN_D];
  assign pinOwned       = s_r.own;
  assign timerMatchFlag = s_r.flag;
  assign periodTimer    = tb.tmr;
  assign dutyBuffer     = s_r.dutyBuf;

  // pins are released the cycle after pwm mode is left
  a_owner_release: assert property (@(posedge clk) disable iff (reset)
    !pwmMode |=> (pinOwned == OWN_RST))
    else $error("pins still owned after pwm mode was left");

  // half bridge never claims c or d
  a_half_cd_free: assert property (@(posedge clk) disable iff (reset)
    halfMode |=> (pinOwned[PIN_C] == 1'b0 && pinOwned[PIN_D] == 1'b0))
    else $error("half bridge claimed an unused pin");

  // single mode claims exactly the steered pins
  a_single_steer: assert property (@(posedge clk) disable iff (reset)
    (pwmMode && outputModeSel == OM_SINGLE) |=> (pinOwned == $past(steerEnable)))
    else $error("single mode ownership differs from steering");

  // no pwm level before the first period boundary
  a_hold_first: assert property (@(posedge clk) disable iff (reset)
    (s_r.st != ST_RUN && !tb.boundary) |=> !s_r.pwmRaw)
    else $error("pwm started before a period boundary");

  // forward direction keeps b and c inactive
  a_fwd_bc_idle: assert property (@(posedge clk) disable iff (reset)
    (running && pwmMode && outputModeSel == OM_FWD && !s_r.dirR && !pending)
      |=> (outB == $past(polV[PIN_B]) && outC == $past(polV[PIN_C])))
    else $error("forward mode drove b or c active");

  // reverse direction keeps a and d inactive
  a_rev_ad_idle: assert property (@(posedge clk) disable iff (reset)
    (running && pwmMode && outputModeSel == OM_REV && s_r.dirR && !pending)
      |=> (outA == $past(polV[PIN_A]) && outD == $past(polV[PIN_D])))
    else $error("reverse mode drove a or d active");

  // during a pending direction change the modulated pin stays inactive
  a_dir_mod_off: assert property (@(posedge clk) disable iff (reset)
    (pending && !s_r.dirR) |=> (outD == $past(polV[PIN_D])))
    else $error("modulated output active during direction change");

  // unmodulated pair swaps in the last prescaled increment
  a_unmod_early: assert property (@(posedge clk) disable iff (reset)
    (pending && tb.lastStep && dirSel) |=> (outC != $past(polV[PIN_C]) && outA == $past(polV[PIN_A])))
    else $error("unmodulated outputs did not swap before period end");

  // duty value is captured at each period start
  a_duty_latch: assert property (@(posedge clk) disable iff (reset)
    tb.boundary |=> (dutyBuffer == $past(dutyNew)))
    else $error("duty not latched at period start");

  // pulse ends on a match of the time base with the buffered duty
  a_pulse_end: assert property (@(posedge clk) disable iff (reset)
    (running && !tb.boundary && timeBase == s_r.dutyBuf) |=> !s_r.pwmRaw)
    else $error("pulse did not end at duty match");

  // flag follows every period start, even against a clear
  a_flag_set: assert property (@(posedge clk) disable iff (reset)
    tb.boundary |=> timerMatchFlag)
    else $error("match flag not set at period start");

  // polarity: an owned idle pin shows its pair's inactive level
  a_polarity_idle: assert property (@(posedge clk) disable iff (reset)
    (pwmMode && !running && outputModeSel == OM_HALF)
      |=> (outA == $past(polV[PIN_A]) && outB == $past(polV[PIN_B])))
    else $error("idle output level ignores polarity");

  // the a/c swap holds through the wrap cycle, so the pair never flips back
  a_unmod_hold: assert property (@(posedge clk) disable iff (reset)
    (pending && tb.boundary && dirSel) |=> (outC != $past(polV[PIN_C]) && outA == $past(polV[PIN_A])))
    else $error("unmodulated outputs flipped back at the period start");

  // full bridge passes the raw level through with no dead band
  a_full_no_delay: assert property (@(posedge clk) disable iff (reset)
    fullMode |=> (deadA == $past(s_r.pwmRaw)))
    else $error("dead band applied in full bridge");

  // a pin the block does not own always reads zero
  a_free_pin_low: assert property (@(posedge clk) disable iff (reset)
    (({outD, outC, outB, outA} & ~pinOwned) == OWN_RST))
    else $error("unowned pin shows a nonzero value");

  // a clear without a period start empties the flag
  a_flag_clear: assert property (@(posedge clk) disable iff (reset)
    (flagClear && !tb.boundary) |=> !timerMatchFlag)
    else $error("match flag survived a clear");

  // the buffered duty only moves at a period start
  a_duty_hold: assert property (@(posedge clk) disable iff (reset)
    !tb.boundary |=> $stable(dutyBuffer))
    else $error("duty buffer changed mid-period");

  // half bridge never shows both switches of the leg active together
  a_half_overlap: assert property (@(posedge clk) disable iff (reset)
    halfMode |=> !((outA ^ $past(polV[PIN_A])) && (outB ^ $past(polV[PIN_B]))))
    else $error("half bridge outputs active together");

  // both full-bridge directions claim all four pins
  a_own_full: assert property (@(posedge clk) disable iff (reset)
    fullMode |=> (pinOwned == OWN_ALL))
    else $error("full bridge did not claim every pin");

endmodule : bridge_pwm_output_steering

// ==== test/pwm_switch_model.sv ====
`timescale 1ns/1ps
// bridge power stage: a/b share one leg, c/d the other
module pwm_switch_model (
  input  wire logic       clk,        // system clock
  input  wire logic       reset,      // asynchronous, active high
  input  wire logic [3:0] pinOut,     // pin values d..a
  input  wire logic [3:0] pinOwned,   // pins driven by the block
  input  wire logic [1:0] polLow,     // bit1 a/c active low, bit0 b/d
  output int              shootCount  // cycles with both switches of a leg on
);
  logic [3:0] act;
  // a released pin is held off by the external pull resistors
  assign act = pinOwned & (pinOut ^ {polLow[0], polLow[1], polLow[0], polLow[1]});
  // count overlap, the stage has no turn-off margin of its own
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shootCount <= 0;
    end else if ((act[0] & act[1]) | (act[2] & act[3])) begin
      shootCount <= shootCount + 1;
    end
  end
endmodule : pwm_switch_model

// ==== test/bridge_pwm_output_steering_tb.sv ====
`timescale 1ns/1ps
module bridge_pwm_output_steering_tb
  import pwm_pkg::*;
;
  logic clk, reset, runBit, flagClr, outA, outB, outC, outD, flag;
  logic [3:0] modeField, steer, owned;
  logic [1:0] outSel, dutyLo, psSel;
  logic [7:0] dutyHi, period, tmr;
  logic [6:0] dbCount;
  logic [9:0] dutyBuf;
  int failCount, checked, shoot, shootNow, waitN;
  int hi[4];
  bridge_pwm_output_steering u_bridge_pwm_output_steering (.clk(clk), .reset(reset),
    .moduleModeField(modeField), .outputModeSel(outSel), .dutyHighByte(dutyHi),
    .dutyLowBits(dutyLo), .deadbandCount(dbCount), .steerEnable(steer), .periodValue(period),
    .timerPrescaleSel(psSel), .timerRunBit(runBit), .flagClear(flagClr), .outA(outA),
    .outB(outB), .outC(outC), .outD(outD), .pinOwned(owned), .timerMatchFlag(flag),
    .periodTimer(tmr), .dutyBuffer(dutyBuf));
  pwm_switch_model u_pwm_switch_model (.clk(clk), .reset(reset), .pinOut({outD, outC, outB, outA}),
    .pinOwned(owned), .polLow(modeField[1:0]), .shootCount(shootNow));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic testDone;
    if (failCount == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : testDone
  task automatic cmpVal(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmpVal
  task automatic pulseClear;
    flagClr = 1'b1;
    @(negedge clk);
    flagClr = 1'b0;
  endtask : pulseClear
  // bounded wait; waitN keeps the number of cycles spent
  task automatic waitFlag;
    waitN = 0;
    while (flag !== 1'b1 && waitN < 300) begin
      @(negedge clk);
      waitN++;
    end
    if (waitN >= 300) cmpVal("flag wait", 10'h001, 10'h000);
  endtask : waitFlag
  // count high cycles over one period, and overlap cycles seen by the stage
  task automatic countHigh;
    shoot = shootNow;
    hi = '{default: 0};
    repeat (16) begin
      @(negedge clk);
      hi[0] += (outA === 1'b1);
      hi[1] += (outB === 1'b1);
      hi[2] += (outC === 1'b1);
      hi[3] += (outD === 1'b1);
    end
    shoot = shootNow - shoot;
  endtask : countHigh
  // configure, let two boundaries pass, then count high cycles over one period
  task automatic runCase(input logic [3:0] mf, input logic [1:0] om, input logic [9:0] duty,
                         input logic [6:0] db, input logic [3:0] st);
    modeField = mf;
    outSel = om;
    {dutyHi, dutyLo} = duty;
    dbCount = db;
    steer = st;
    pulseClear;
    waitFlag;
    pulseClear;
    waitFlag;
    countHigh;
  endtask : runCase
  task automatic cmpHi(input int a, input int b, input int c, input int d);
    cmpVal("high a", 10'(a), 10'(hi[0]));
    cmpVal("high b", 10'(b), 10'(hi[1]));
    cmpVal("high c", 10'(c), 10'(hi[2]));
    cmpVal("high d", 10'(d), 10'(hi[3]));
  endtask : cmpHi
  task automatic checkIdle;
    cmpVal("pins", 10'h000, {6'h00, outD, outC, outB, outA});
    cmpVal("owned", 10'h000, {6'h00, owned});
    cmpVal("flag", 10'h000, {9'h000, flag});
    cmpVal("timer", 10'h000, {2'h0, tmr});
    cmpVal("duty buffer", 10'h000, dutyBuf);
  endtask : checkIdle
  task automatic testSingle;
    runCase(4'hC, OM_SINGLE, 10'h006, 7'h00, 4'h5);
    cmpVal("owned single", 10'h005, {6'h00, owned});
    cmpHi(6, 0, 6, 0);
    cmpVal("duty buffer", 10'h006, dutyBuf);
    runCase(4'hC, OM_SINGLE, 10'h003, 7'h00, 4'hA);
    cmpHi(0, 3, 0, 3);
  endtask : testSingle
  task automatic testHalf;
    runCase(4'hC, OM_HALF, 10'h006, 7'h00, 4'h0);
    cmpVal("owned half", 10'h003, {6'h00, owned});
    cmpHi(6, 10, 0, 0);
    cmpVal("shoot half", 10'h000, 10'(shoot));
    // forty clocks of dead band exceed both pulses
    runCase(4'hC, OM_HALF, 10'h006, 7'h0A, 4'h0);
    cmpHi(0, 0, 0, 0);
  endtask : testHalf
  task automatic testFull;
    runCase(4'hC, OM_FWD, 10'h005, 7'h0A, 4'h0);
    cmpVal("owned full", 10'h00F, {6'h00, owned});
    cmpHi(16, 0, 0, 5);
    runCase(4'hC, OM_REV, 10'h005, 7'h0A, 4'h0);
    cmpHi(0, 5, 16, 0);
    cmpVal("shoot full", 10'h000, 10'(shoot));
    runCase(4'hE, OM_FWD, 10'h005, 7'h00, 4'h0);
    cmpHi(0, 0, 16, 5);
    runCase(4'hD, OM_FWD, 10'h005, 7'h00, 4'h0);
    cmpHi(16, 16, 0, 11);
  endtask : testFull
  // flip forward to reverse right at a period start: d never rises, the a/c
  // pair swaps in the last increment and stays swapped through the wrap
  task automatic testDir;
    runCase(4'hC, OM_FWD, 10'h005, 7'h00, 4'h0);
    outSel = OM_REV;
    countHigh;
    cmpHi(14, 0, 2, 0);
    cmpVal("shoot flip", 10'h000, 10'(shoot));
  endtask : testDir
  task automatic testFlag;
    pulseClear;
    cmpVal("flag cleared", 10'h000, {9'h000, flag});
    waitFlag;
    cmpVal("timer at boundary", 10'h000, {2'h0, tmr});
    pulseClear;
    waitFlag;
    cmpVal("period /1", 10'd15, 10'(waitN));
    psSel = PS_SEL_DIV4;
    pulseClear;
    waitFlag;
    pulseClear;
    waitFlag;
    cmpVal("period /4", 10'd63, 10'(waitN));
    psSel = PS_SEL_DIV1;
  endtask : testFlag
  task automatic testRelease;
    modeField = 4'h0;
    repeat (3) @(negedge clk);
    cmpVal("owned off", 10'h000, {6'h00, owned});
    cmpVal("pins off", 10'h000, {6'h00, outD, outC, outB, outA});
    // pwm chosen again, not yet running: owned pins idle at the inactive level
    modeField = 4'hF;
    outSel = OM_HALF;
    repeat (2) @(negedge clk);
    cmpVal("pins armed", 10'h003, {6'h00, outD, outC, outB, outA});
  endtask : testRelease
  task automatic testReset;
    runCase(4'hC, OM_FWD, 10'h005, 7'h00, 4'h0);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    checkIdle;
    reset = 1'b0;
  endtask : testReset
  // watchdog, generous against roughly seven hundred cycles of tests
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    testDone;
  end
  // set-up order: period, mode, duty, clear flag, prescale, run
  initial begin
    reset = 1'b1;
    {runBit, flagClr} = 2'b00;
    {modeField, steer, outSel, dutyLo, psSel, dutyHi, dbCount} = '0;
    period = 8'h03;
    failCount = 0;
    checked = 0;
    repeat (12) @(negedge clk);
    checkIdle;
    reset = 1'b0;
    runBit = 1'b1;
    testFlag;
    testSingle;
    testHalf;
    testFull;
    testDir;
    testRelease;
    testReset;
    testDone;
  end
endmodule : bridge_pwm_output_steering_tb
